/* File: common/sfr_pkg.sv */
// Constants and types shared by the serial flash read engine
package sfr_pkg;

   // -----------------------------------------------
   // Command opcodes
   // -----------------------------------------------
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST = 8'h0b;
   localparam logic [7:0] OP_DOUT = 8'h3b;
   localparam logic [7:0] OP_QOUT = 8'h6b;
   localparam logic [7:0] OP_DIO  = 8'hbb;
   localparam logic [7:0] OP_QIO  = 8'heb;
   localparam logic [7:0] OP_WORD = 8'he7;
   localparam logic [7:0] OP_WRAP = 8'h77;

   // -----------------------------------------------
   // Phase lengths in bits or clocks, and the mode skip code
   // -----------------------------------------------
   localparam logic [5:0] CMD_BITS  = 6'd8;
   localparam logic [5:0] ADDR_BITS = 6'd24;
   localparam logic [5:0] MODE_BITS = 6'd8;
   localparam logic [5:0] WRAP_BITS = 6'd32;
   localparam logic [5:0] BYTE_BITS = 6'd8;
   localparam logic [5:0] DUM_FAST  = 6'd8;
   localparam logic [5:0] DUM_QIO   = 6'd4;
   localparam logic [5:0] DUM_WORD  = 6'd2;
   localparam logic [1:0] SKIP_CODE = 2'b10;

   // -----------------------------------------------
   // Register offsets, fields and reset values
   // -----------------------------------------------
   localparam int         ADR_W      = 8;
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STAT   = 8'h04;
   localparam logic [7:0] REG_MADDR  = 8'h08;
   localparam logic [7:0] REG_MDATA  = 8'h0c;
   localparam int         CTRL_QE    = 0;
   localparam int         CTRL_BUSY  = 1;
   localparam logic [2:0] WRAP_RST   = 3'h1;
   localparam logic [7:0] ERASED     = 8'hff;

   // -----------------------------------------------
   // Engine states
   // -----------------------------------------------
   typedef enum {
      ST_IDLE, ST_CMD, ST_ADDR, ST_MODE,
      ST_DUMMY, ST_DATA, ST_WRAP, ST_IGNORE
   } sfr_state_e;

endpackage

/* File: rtl/sfr_read_engine.sv */
// Serial flash read engine with Wishbone register access
//
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
// Function
// - Basic read: select low, opcode 03h, 24-bit address MSB first on line zero
// - Opcode and address bits are sampled on rising serial clock
// - Data bytes change on falling clock edge, MSB first
// - Address advances per byte, streaming until select rises
// - Read commands are ignored while a write cycle is busy; reads that skip the opcode do not check busy_r
// - Opcode 0Bh has eight dummy clocks; input ignored during them
// - Opcode 3Bh: single-line address, eight dummies, two-bit data out
// - Opcode 6Bh: single-line address, four-bit data after dummies
// - Quad opcodes refused unless quad mode enable is set
// - Opcode BBh: address two bits per clock, data two bits per clock
// - Dual and quad I/O reads take eight mode bits after address
// - Low mode nibble ignored; host may leave it undriven
// - Opcode EBh: four-bit address and data, dummies before data
// - Mode bits five-four equal 10 make next read skip opcode
// - Any other mode bits five-four restore full opcode next time
// - Wrapped quad reads stay in aligned 8/16/32/64-byte section
// - Three wrap bits: wrap disable at bit four (zero enables wrap), length at six-five
// - Opcode E7h uses even address and two dummy clocks; address bit zero is neither forced nor checked
// - Wrap disable resets to one; lengths 8, 16, 32, 64 bytes
// - Opcode 77h: 24 dummy bits then eight wrap bits
module sfr_read_engine #(
   parameter int MEM_AW = 8
) (
   // Clock and reset
   input  wire logic                      CLOCK_I,
   input  wire logic                      RESET_I,
   // Serial link
   input  wire logic                      SPI_CS_N_I,
   input  wire logic                      SPI_SCLK_I,
   input  wire logic [3:0]                SPI_DATA_LINE_I,
   output logic      [3:0]                SPI_DATA_LINE_O,
   output logic      [3:0]                SPI_DATA_LINE_OE_O,
   // Wishbone slave
   input  wire logic                      WB_CYC_I,
   input  wire logic                      WB_STB_I,
   input  wire logic                      WB_WE_I,
   input  wire logic [sfr_pkg::ADR_W-1:0] WB_ADR_I,
   input  wire logic [3:0]                WB_SEL_I,
   input  wire logic [31:0]               WB_DAT_I,
   output logic      [31:0]               WB_DAT_O,
   output logic                           WB_ACK_O
);
   import sfr_pkg::*;

   // -----------------------------------------------
   // Decode functions
   // -----------------------------------------------
   function automatic logic op_ok(input logic [7:0] op);
      case (op)
         OP_READ, OP_FAST, OP_DOUT, OP_QOUT,
         OP_DIO, OP_QIO, OP_WORD, OP_WRAP: op_ok = 1'b1;
         default: op_ok = 1'b0;
      endcase
   endfunction

   function automatic logic op_quad(input logic [7:0] op);
      case (op)
         OP_QOUT, OP_QIO, OP_WORD, OP_WRAP: op_quad = 1'b1;
         default: op_quad = 1'b0;
      endcase
   endfunction

   function automatic logic op_mode(input logic [7:0] op);
      case (op)
         OP_DIO, OP_QIO, OP_WORD: op_mode = 1'b1;
         default: op_mode = 1'b0;
      endcase
   endfunction

   function automatic logic op_wrap(input logic [7:0] op);
      op_wrap = (op == OP_QIO) || (op == OP_WORD);
   endfunction

   function automatic logic [2:0] op_aw(input logic [7:0] op);
      case (op)
         OP_DIO: op_aw = 3'd2;
         OP_QIO, OP_WORD, OP_WRAP: op_aw = 3'd4;
         default: op_aw = 3'd1;
      endcase
   endfunction

   function automatic logic [2:0] op_dw(input logic [7:0] op);
      case (op)
         OP_READ, OP_FAST: op_dw = 3'd1;
         OP_DOUT, OP_DIO: op_dw = 3'd2;
         default: op_dw = 3'd4;
      endcase
   endfunction

   function automatic logic [5:0] op_dum(input logic [7:0] op);
      case (op)
         OP_READ, OP_DIO: op_dum = 6'd0;
         OP_QIO: op_dum = DUM_QIO;
         OP_WORD: op_dum = DUM_WORD;
         default: op_dum = DUM_FAST;
      endcase
   endfunction

   function automatic logic [23:0] shift_in(input logic [23:0] v,
                                            input logic [2:0] w,
                                            input logic [3:0] d);
      case (w)
         3'd1: shift_in = {v[22:0], d[0]};
         3'd2: shift_in = {v[21:0], d[1:0]};
         default: shift_in = {v[19:0], d};
      endcase
   endfunction

   function automatic logic [23:0] next_addr(input logic [23:0] a,
                                             input logic en,
                                             input logic [1:0] len);
      logic [5:0] m;
      logic [5:0] low;
      m = 6'h07;
      low = a[5:0] + 6'd1;
      case (len)
         2'd0: m = 6'h07;
         2'd1: m = 6'h0f;
         2'd2: m = 6'h1f;
         default: m = 6'h3f;
      endcase
      if (en) begin
         next_addr = {a[23:6], (a[5:0] & ~m) | (low & m)};
      end else begin
         next_addr = a + 24'd1;
      end
   endfunction

   // -----------------------------------------------
   // Link synchronisers and edge detect
   // -----------------------------------------------
   logic       cs_m, cs_s;
   logic       sck_m, sck_s, sck_d;
   logic [3:0] d_m, d_s;

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         cs_m  <= 1'b1;
         cs_s  <= 1'b1;
         sck_m <= 1'b0;
         sck_s <= 1'b0;
         sck_d <= 1'b0;
         d_m   <= 4'h0;
         d_s   <= 4'h0;
      end else begin
         cs_m  <= SPI_CS_N_I;
         cs_s  <= cs_m;
         sck_m <= SPI_SCLK_I;
         sck_s <= sck_m;
         sck_d <= sck_s;
         d_m   <= SPI_DATA_LINE_I;
         d_s   <= d_m;
      end
   end

   wire sck_rise = sck_s & ~sck_d;
   wire sck_fall = ~sck_s & sck_d;

   // -----------------------------------------------
   // Control registers and array storage
   // -----------------------------------------------
   logic              qe_r, busy_r, ack_r;
   logic [31:0]       dat_r;
   logic [MEM_AW-1:0] maddr_r;
   logic [7:0]        mem [2**MEM_AW];
   logic [2:0]        wrap_r;
   logic              cont_r;
   logic [7:0]        op_r;
   sfr_state_e        st_r;

   wire wb_req = WB_CYC_I & WB_STB_I & ~ack_r;
   wire wb_wr  = wb_req & WB_WE_I & WB_SEL_I[0];

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         ack_r   <= 1'b0;
         dat_r   <= 32'h0;
         qe_r    <= 1'b0;
         busy_r  <= 1'b0;
         maddr_r <= '0;
      end else begin
         ack_r <= wb_req;
         if (wb_req) begin
            case (WB_ADR_I)
               REG_CTRL:  dat_r <= {30'h0, busy_r, qe_r};
               REG_STAT:  dat_r <= {16'h0, 4'(st_r), op_r, cont_r, wrap_r};
               REG_MADDR: dat_r <= 32'(maddr_r);
               REG_MDATA: dat_r <= {24'h0, mem[maddr_r]};
               default:   dat_r <= 32'h0;
            endcase
         end
         if (wb_wr && WB_ADR_I == REG_CTRL) begin
            qe_r   <= WB_DAT_I[CTRL_QE];
            busy_r <= WB_DAT_I[CTRL_BUSY];
         end
         if (wb_wr && WB_ADR_I == REG_MADDR) begin
            maddr_r <= WB_DAT_I[MEM_AW-1:0];
         end
      end
   end

   assign WB_ACK_O = ack_r;
   assign WB_DAT_O = dat_r;

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         for (int i = 0; i < 2**MEM_AW; i++) begin
            mem[i] <= ERASED;
         end
      end else if (wb_wr && WB_ADR_I == REG_MDATA) begin
         mem[maddr_r] <= WB_DAT_I[7:0];
      end
   end

   // -----------------------------------------------
   // Command engine
   // -----------------------------------------------
   logic [5:0]  cnt_r;
   logic [23:0] sr_r, addr_r;
   logic [7:0]  out_sr_r;
   logic        ld_r;
   logic [3:0]  out_r, oe_r;
   logic [2:0]  step;

   always_comb begin
      case (st_r)
         ST_ADDR, ST_MODE: step = op_aw(op_r);
         ST_WRAP: step = 3'd4;
         ST_DATA: step = op_dw(op_r);
         default: step = 3'd1;
      endcase
   end

   wire [5:0]  cnt_sum  = cnt_r + {3'b0, step};
   wire [23:0] sr_nxt   = shift_in(sr_r, step, d_s);
   wire [23:0] addr_nxt = shift_in(addr_r, step, d_s);
   wire        wrap_on  = op_wrap(op_r) & ~wrap_r[0];
   wire [5:0]  dum      = op_dum(op_r);
   wire        byte_end = (st_r == ST_DATA) & ~ld_r & sck_fall & (cnt_sum == BYTE_BITS);

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         st_r     <= ST_IDLE;
         cnt_r    <= 6'd0;
         sr_r     <= 24'h0;
         addr_r   <= 24'h0;
         op_r     <= 8'h0;
         cont_r   <= 1'b0;
         wrap_r   <= WRAP_RST;
         out_sr_r <= 8'h0;
         ld_r     <= 1'b0;
         out_r    <= 4'h0;
         oe_r     <= 4'h0;
      end else if (cs_s) begin
         st_r  <= ST_IDLE;
         oe_r  <= 4'h0;
         out_r <= 4'h0;
      end else begin
         case (st_r)
            ST_IDLE: begin
               cnt_r <= 6'd0;
               sr_r  <= 24'h0;
               st_r  <= cont_r ? ST_ADDR : ST_CMD;
            end
            ST_CMD: begin
               if (sck_rise) begin
                  sr_r  <= sr_nxt;
                  cnt_r <= cnt_sum;
                  if (cnt_sum == CMD_BITS) begin
                     cnt_r <= 6'd0;
                     op_r  <= sr_nxt[7:0];
                     if (!op_ok(sr_nxt[7:0]) || busy_r) begin
                        st_r <= ST_IGNORE;
                     end else if (op_quad(sr_nxt[7:0]) && !qe_r) begin
                        st_r <= ST_IGNORE;
                     end else if (sr_nxt[7:0] == OP_WRAP) begin
                        st_r <= ST_WRAP;
                     end else begin
                        st_r <= ST_ADDR;
                     end
                  end
               end
            end
            ST_ADDR: begin
               if (sck_rise) begin
                  addr_r <= addr_nxt;
                  cnt_r  <= cnt_sum;
                  if (cnt_sum == ADDR_BITS) begin
                     cnt_r <= 6'd0;
                     if (op_mode(op_r)) begin
                        st_r <= ST_MODE;
                     end else if (dum != 6'd0) begin
                        st_r <= ST_DUMMY;
                     end else begin
                        st_r <= ST_DATA;
                        ld_r <= 1'b1;
                     end
                  end
               end
            end
            ST_MODE: begin
               if (sck_rise) begin
                  sr_r  <= sr_nxt;
                  cnt_r <= cnt_sum;
                  if (cnt_sum == MODE_BITS) begin
                     cnt_r  <= 6'd0;
                     cont_r <= (sr_nxt[5:4] == SKIP_CODE);
                     if (dum != 6'd0) begin
                        st_r <= ST_DUMMY;
                     end else begin
                        st_r <= ST_DATA;
                        ld_r <= 1'b1;
                     end
                  end
               end
            end
            ST_DUMMY: begin
               if (sck_rise) begin
                  cnt_r <= cnt_sum;
                  if (cnt_sum == dum) begin
                     cnt_r <= 6'd0;
                     st_r  <= ST_DATA;
                     ld_r  <= 1'b1;
                  end
               end
            end
            ST_WRAP: begin
               if (sck_rise) begin
                  sr_r  <= sr_nxt;
                  cnt_r <= cnt_sum;
                  if (cnt_sum == WRAP_BITS) begin
                     wrap_r <= sr_nxt[6:4];
                     st_r   <= ST_IGNORE;
                  end
               end
            end
            ST_DATA: begin
               if (ld_r) begin
                  out_sr_r <= mem[addr_r[MEM_AW-1:0]];
                  ld_r     <= 1'b0;
               end else if (sck_fall) begin
                  case (step)
                     3'd1: begin
                        out_r <= {2'b00, out_sr_r[7], 1'b0};
                        oe_r  <= 4'b0010;
                     end
                     3'd2: begin
                        out_r <= {2'b00, out_sr_r[7:6]};
                        oe_r  <= 4'b0011;
                     end
                     default: begin
                        out_r <= out_sr_r[7:4];
                        oe_r  <= 4'b1111;
                     end
                  endcase
                  out_sr_r <= out_sr_r << step;
                  cnt_r    <= cnt_sum;
                  if (byte_end) begin
                     cnt_r  <= 6'd0;
                     addr_r <= next_addr(addr_r, wrap_on, wrap_r[2:1]);
                     ld_r   <= 1'b1;
                  end
               end
            end
            ST_IGNORE: begin
               cnt_r <= 6'd0;
            end
            default: begin
               st_r <= ST_IDLE;
            end
         endcase
      end
   end

   assign SPI_DATA_LINE_O    = out_r;
   assign SPI_DATA_LINE_OE_O = oe_r;

   // -----------------------------------------------
   // Assertions
   // -----------------------------------------------
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RESET_I);

   wire cmd_done = !cs_s && st_r == ST_CMD && sck_rise && cnt_sum == CMD_BITS;

   property p_read_start;
      cmd_done && sr_nxt[7:0] == OP_READ && !busy_r |=> st_r == ST_ADDR ##1 !cs_s [*1];
   endproperty
   a_read_start: assert property (p_read_start) else $error("read opcode not accepted");

   property p_addr_hold;
      !cs_s && st_r == ST_ADDR && !sck_rise |=> $stable(addr_r);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved off rising edge");

   property p_msb_first;
      !cs_s && st_r == ST_DATA && !ld_r && sck_fall && step == 3'd1
         |=> out_r[1] == $past(out_sr_r[7]) && oe_r == 4'b0010;
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("single data bit wrong");

   property p_incr;
      !cs_s && byte_end && !wrap_on |=> addr_r == $past(addr_r) + 24'd1;
   endproperty
   a_incr: assert property (p_incr) else $error("address did not advance");

   property p_busy;
      cmd_done && busy_r |=> st_r == ST_IGNORE;
   endproperty
   a_busy: assert property (p_busy) else $error("command taken while busy");

   property p_dummy;
      st_r == ST_DUMMY |=> $stable(addr_r) && $stable(wrap_r);
   endproperty
   a_dummy: assert property (p_dummy) else $error("dummy clock changed state");

   property p_quad_refuse;
      cmd_done && op_quad(sr_nxt[7:0]) && !qe_r |=> st_r == ST_IGNORE;
   endproperty
   a_quad_refuse: assert property (p_quad_refuse) else $error("quad opcode without enable");

   property p_skip;
      st_r == ST_IDLE && !cs_s && cont_r |=> st_r == ST_ADDR;
   endproperty
   a_skip: assert property (p_skip) else $error("opcode not skipped");

   property p_no_skip;
      !cs_s && st_r == ST_MODE && sck_rise && cnt_sum == MODE_BITS
         && sr_nxt[5:4] != SKIP_CODE |=> !cont_r;
   endproperty
   a_no_skip: assert property (p_no_skip) else $error("continuous mode kept");

   property p_wrap_section;
      !cs_s && byte_end && wrap_on |=> addr_r[23:6] == $past(addr_r[23:6]);
   endproperty
   a_wrap_section: assert property (p_wrap_section) else $error("wrap left section");

endmodule

/* File: sim/sfr_host_model.sv */
// Host-side model of the serial link: select, clock and data lines
`timescale 1ns/1ps
module sfr_host_model (
   // Clock
   input  wire logic       clk_i,
   // Link
   output logic            cs_n_o,
   output logic            sclk_o,
   output logic [3:0]      line_o,
   input  wire logic [3:0] dev_d_i,
   input  wire logic [3:0] dev_oe_i
);
   logic [3:0] drv_r = 4'h0;
   logic [3:0] hoe_r = 4'h0;

   // -----------------------------------------------
   // Wire level: device, else host, else inverse of last host value
   // -----------------------------------------------
   assign line_o = (dev_oe_i & dev_d_i) | (~dev_oe_i & hoe_r & drv_r) | (~dev_oe_i & ~hoe_r & ~drv_r);

   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
   end

   task automatic sel();
      @(posedge clk_i);
      cs_n_o <= 1'b0;
   endtask

   task automatic desel();
      @(posedge clk_i);
      sclk_o <= 1'b0;
      repeat (16) @(posedge clk_i);
      cs_n_o <= 1'b1;
      hoe_r  <= 4'h0;
      repeat (8) @(posedge clk_i);
   endtask

   // -----------------------------------------------
   // Clock groups: drive wo bits after falling edge, sample wi bits at rising
   // -----------------------------------------------
   task automatic xfer(input int wo, input int wi, input int n, input logic [63:0] v,
                       inout logic [63:0] r, inout logic [3:0] oe);
      logic [3:0] m;
      m = 4'((1 << wo) - 1);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         sclk_o <= 1'b0;
         hoe_r  <= m;
         if (wo != 0) drv_r <= 4'(v >> ((n - 1 - i) * wo)) & m;
         repeat (16) @(posedge clk_i);
         oe = oe | dev_oe_i;
         if (wi == 1) r = {r[62:0], line_o[1]};
         else if (wi == 2) r = {r[61:0], line_o[1:0]};
         else if (wi == 4) r = {r[59:0], line_o};
         sclk_o <= 1'b1;
         repeat (15) @(posedge clk_i);
      end
   endtask
endmodule

/* File: sim/sfr_read_engine_tb_top.sv */
// Self-checking bench for the serial flash read engine
`timescale 1ns/1ps
module sfr_read_engine_tb_top;
   import sfr_pkg::*;
   localparam int AW = 4;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we  = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'hf;
   logic [31:0] dat = 32'h0;
   logic [31:0] dato;
   logic        ack;
   logic        cs_n;
   logic        sclk;
   logic [3:0]  line;
   logic [3:0]  dq_o;
   logic [3:0]  dq_oe;
   int          failures = 0;
   int          n_tests = 0;
   int          cycles = 0;

   always #2.5 clk = ~clk;

   sfr_read_engine #(.MEM_AW(AW)) dut (.CLOCK_I(clk), .RESET_I(rst), .SPI_CS_N_I(cs_n), .SPI_SCLK_I(sclk),
      .SPI_DATA_LINE_I(line), .SPI_DATA_LINE_O(dq_o), .SPI_DATA_LINE_OE_O(dq_oe), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dato),
      .WB_ACK_O(ack));
   sfr_host_model host (.clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .line_o(line), .dev_d_i(dq_o),
      .dev_oe_i(dq_oe));

   // -----------------------------------------------
   // Helpers
   // -----------------------------------------------
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         failures = failures + 1;
         complete_run();
      end
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      @(posedge clk);
      while (ack !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (n == 50) failures++;
      q = dato;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   function automatic logic [7:0] bv(input logic [AW-1:0] i);
      return 8'h5a ^ (8'(i) * 8'h13);
   endfunction

   function automatic logic [63:0] expd(input logic [23:0] a, input int nb, input int wl);
      logic [63:0] e;
      logic [23:0] x;
      e = '0;
      for (int k = 0; k < nb; k++) begin
         x = (wl == 0) ? a + 24'(k) : (a & ~24'(wl - 1)) | ((a + 24'(k)) & 24'(wl - 1));
         e = {e[55:0], bv(x[AW-1:0])};
      end
      return e;
   endfunction

   task automatic frame(input logic [7:0] op, input logic skip, input int aw, input logic [23:0] a,
                        input logic [7:0] m, input int dum, input int dw, input int nb,
                        output logic [63:0] r, output logic [3:0] oe);
      r = '0;
      oe = '0;
      host.sel();
      if (!skip) host.xfer(1, 0, 8, 64'(op), r, oe);
      host.xfer(aw, 0, 24 / aw, 64'(a), r, oe);
      if (aw > 1) host.xfer(aw, 0, 8 / aw, 64'(m), r, oe);
      host.xfer(0, 0, dum, 64'h0, r, oe);
      oe = '0;
      host.xfer(0, dw, nb * 8 / dw, 64'h0, r, oe);
      host.desel();
   endtask

   // -----------------------------------------------
   // Scenarios
   // -----------------------------------------------
   task automatic t_regs();
      logic [31:0] q;
      wb(1'b0, REG_STAT, 32'h0, q);
      chk(q[2:0], 3'b001);
      wb(1'b0, 8'h10, 32'h0, q);
      chk(q, 32'h0);
      for (int i = 0; i < 16; i++) begin
         wb(1'b1, REG_MADDR, 32'(i), q);
         wb(1'b1, REG_MDATA, 32'(bv(4'(i))), q);
      end
      wb(1'b0, REG_MDATA, 32'h0, q);
      chk(q[7:0], bv(4'hf));
   endtask

   task automatic t_single();
      logic [63:0] r;
      logic [3:0]  oe;
      frame(OP_READ, 1'b0, 1, 24'h00000e, 8'h0, 0, 1, 4, r, oe);
      chk(r, expd(24'h00000e, 4, 0));
      chk(oe, 4'h2);
      frame(OP_FAST, 1'b0, 1, 24'h000003, 8'h0, 8, 1, 3, r, oe);
      chk(r, expd(24'h000003, 3, 0));
   endtask

   task automatic t_busy();
      logic [63:0] r;
      logic [3:0]  oe;
      logic [31:0] q;
      wb(1'b1, REG_CTRL, 32'h2, q);
      frame(OP_READ, 1'b0, 1, 24'h000001, 8'h0, 0, 1, 2, r, oe);
      chk(oe, 4'h0);
      wb(1'b1, REG_CTRL, 32'h0, q);
      frame(OP_QOUT, 1'b0, 1, 24'h000001, 8'h0, 8, 4, 2, r, oe);
      chk(oe, 4'h0);
   endtask

   task automatic t_multi();
      logic [63:0] r;
      logic [3:0]  oe;
      logic [31:0] q;
      wb(1'b1, REG_CTRL, 32'h1, q);
      frame(OP_DOUT, 1'b0, 1, 24'h000007, 8'h0, 8, 2, 3, r, oe);
      chk(r, expd(24'h000007, 3, 0));
      chk(oe, 4'h3);
      frame(OP_QOUT, 1'b0, 1, 24'h000009, 8'h0, 8, 4, 4, r, oe);
      chk(r, expd(24'h000009, 4, 0));
      chk(oe, 4'hf);
   endtask

   task automatic t_cont();
      logic [63:0] r;
      logic [3:0]  oe;
      logic [31:0] q;
      frame(OP_DIO, 1'b0, 2, 24'h000005, 8'h2a, 0, 2, 2, r, oe);
      chk(r, expd(24'h000005, 2, 0));
      wb(1'b0, REG_STAT, 32'h0, q);
      chk(q[3], 1'b1);
      frame(OP_DIO, 1'b1, 2, 24'h00000c, 8'hff, 0, 2, 3, r, oe);
      chk(r, expd(24'h00000c, 3, 0));
      wb(1'b0, REG_STAT, 32'h0, q);
      chk(q[3], 1'b0);
      frame(OP_QIO, 1'b0, 4, 24'h000002, 8'h20, 4, 4, 3, r, oe);
      chk(r, expd(24'h000002, 3, 0));
      frame(OP_QIO, 1'b1, 4, 24'h00000b, 8'h05, 4, 4, 3, r, oe);
      chk(r, expd(24'h00000b, 3, 0));
      frame(OP_WORD, 1'b0, 4, 24'h000004, 8'h00, 2, 4, 4, r, oe);
      chk(r, expd(24'h000004, 4, 0));
      frame(OP_QIO, 1'b0, 4, 24'h000002, 8'h20, 4, 4, 1, r, oe);
      host.sel();
      host.xfer(1, 0, 8, 64'hff, r, oe);
      host.desel();
      wb(1'b0, REG_STAT, 32'h0, q);
      chk(q[3], 1'b0);
      frame(OP_DIO, 1'b0, 2, 24'h000005, 8'h2a, 0, 2, 1, r, oe);
      host.sel();
      host.xfer(1, 0, 16, 64'hffff, r, oe);
      host.desel();
      wb(1'b0, REG_STAT, 32'h0, q);
      chk(q[3], 1'b0);
   endtask

   task automatic t_wrap();
      logic [63:0] r;
      logic [3:0]  oe;
      logic [31:0] q;
      frame(OP_WRAP, 1'b0, 4, 24'h0, 8'h00, 0, 1, 0, r, oe);
      wb(1'b0, REG_STAT, 32'h0, q);
      chk(q[2:0], 3'b000);
      frame(OP_QIO, 1'b0, 4, 24'h00000d, 8'h00, 4, 4, 6, r, oe);
      chk(r, expd(24'h00000d, 6, 8));
      frame(OP_WRAP, 1'b0, 4, 24'h0, 8'h30, 0, 1, 0, r, oe);
      frame(OP_WORD, 1'b0, 4, 24'h00000e, 8'h00, 2, 4, 6, r, oe);
      chk(r, expd(24'h00000e, 6, 0));
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      t_regs();
      t_single();
      t_busy();
      t_multi();
      t_cont();
      t_wrap();
      complete_run();
   end
endmodule
